// ### pbl_pkg.sv
// Shared constants and types for the parallel I/O boot loader link
package pbl_pkg;

  // Port and word geometry
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam logic [15:0] IO_PORT_ADDR = 16'h0000;
  localparam logic [15:0] SEL_PORT_ADDR = 16'hFFFF;

  // Selection word encodings (low nibble)
  localparam logic [3:0] SEL_IO_BYTE = 4'h8;
  localparam logic [3:0] SEL_IO_WORD = 4'hC;

  // Timing: clock 50 MHz, least write delay is ten clocks
  localparam int CLK_PERIOD_NS = 20;
  localparam int WRITE_DLY_NS = 200;
  localparam int WRITE_DLY_CYC_I = (WRITE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WRITE_DLY_CYC = 4'(WRITE_DLY_CYC_I);
  localparam logic [3:0] SEL_WAIT_CYC = 4'h8;

  // Reset values
  localparam logic ACK_RESET = 1'b1;
  localparam logic STROBE_RESET = 1'b1;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [3:0] CNT_RESET = 4'h0;

  // Device loader states
  typedef enum logic [2:0] {
    DEV_SEL = 3'b000,
    DEV_WAIT_LO = 3'b001,
    DEV_HOLD = 3'b010,
    DEV_WAIT_HI = 3'b011,
    DEV_DONE = 3'b100,
    DEV_ERR = 3'b101
  } pbl_dev_state_t;

  // Header and code phases of the incoming stream
  typedef enum logic [1:0] {
    PH_DEST = 2'b00,
    PH_LEN = 2'b01,
    PH_CODE = 2'b10
  } pbl_phase_t;

  // Host sender states
  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_SETUP = 2'b01,
    HST_STRB = 2'b10,
    HST_WAIT = 2'b11
  } pbl_host_state_t;

endpackage : pbl_pkg

// ### pbl_link_if.sv
// Handshake link between the boot loader and the host processor
`timescale 1ns/100ps
interface pbl_link_if;
  logic host_strobe_in;     // Active-low transfer strobe from host
  logic ack_flag_out;       // Acknowledge flag from device
  logic [15:0] port_data;   // Host data onto the I/O port
  logic port_data_oe;       // High while host drives port_data
  logic [15:0] io_addr;     // Device I/O port address
  logic io_rd;              // Device I/O read in progress

  // Device end
  modport dev_mp (
    input host_strobe_in,
    input port_data,
    input port_data_oe,
    output ack_flag_out,
    output io_addr,
    output io_rd
  );

  // Host end
  modport host_mp (
    output host_strobe_in,
    output port_data,
    output port_data_oe,
    input ack_flag_out,
    input io_addr,
    input io_rd
  );
endinterface : pbl_link_if

// ### pbl_fifo.sv
// Synchronous word FIFO with valid/ready on both sides
`timescale 1ns/100ps
module pbl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage array
  logic [AW-1:0] wr_ptr_q;          // Next slot to write
  logic [AW-1:0] rd_ptr_q;          // Next slot to read
  logic [AW:0] count_q;             // Words held
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Flags straight from the count, so full and empty are exact
  assign in_ready = (count_q != DEPTH_C);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  //////////////////////////////////////////////////////////////////////////////
  // Storage write, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule : pbl_fifo

// ### pbl_host.sv
// Host end: buffers boot words and sends them over the strobe/ack handshake
`timescale 1ns/100ps
module pbl_host (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic byte_mode,
  input wire logic [15:0] boot_sel,
  input wire logic word_valid,
  output logic word_ready,
  input wire logic [15:0] word_data,
  output logic busy,
  pbl_link_if.host_mp link
);
  pbl_pkg::pbl_host_state_t state_q;   // Sender state
  logic ack_s1_q;                      // Ack sync stage 1
  logic ack_s2_q;                      // Ack sync stage 2
  logic rd_s1_q;                       // Read sync stage 1
  logic rd_s2_q;                       // Read sync stage 2
  logic [15:0] addr_s1_q;              // Address sync stage 1
  logic [15:0] addr_s2_q;              // Address sync stage 2
  logic strobe_q;                      // Strobe pin, active low
  logic oe_q;                          // Bus drive enable
  logic [15:0] data_q;                 // Bus value
  logic lo_q;                          // Low byte is next in byte mode
  logic pop_q;                         // One-cycle FIFO pop
  logic busy_q;                        // Work pending
  logic fifo_valid;
  logic fifo_ready;
  logic [15:0] fifo_data;

  // Buffer stalls the user once 32 words wait
  pbl_fifo #(.WIDTH(pbl_pkg::WORD_W), .DEPTH(pbl_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(word_valid),
    .in_ready(fifo_ready),
    .in_data(word_data),
    .out_valid(fifo_valid),
    .out_ready(pop_q),
    .out_data(fifo_data)
  );

  // Decode and next bus value
  wire sel_rd = rd_s2_q && (addr_s2_q == pbl_pkg::SEL_PORT_ADDR);
  wire [15:0] hi_byte = {8'h00, fifo_data[15:8]};
  wire [15:0] lo_byte = {8'h00, fifo_data[7:0]};
  wire [15:0] send_val = byte_mode ? (lo_q ? lo_byte : hi_byte) : fifo_data;
  wire last_piece = !byte_mode || lo_q;

  assign word_ready = fifo_ready;
  assign busy = busy_q;
  assign link.host_strobe_in = strobe_q;
  assign link.port_data_oe = oe_q;
  // Released bus shows the inverse, so a late sample cannot pass as good data
  assign link.port_data = oe_q ? data_q : ~data_q;

  //////////////////////////////////////////////////////////////////////////////
  // Device pins are another party's, so they pass two flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_s1_q <= pbl_pkg::ACK_RESET;
      ack_s2_q <= pbl_pkg::ACK_RESET;
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
      addr_s1_q <= pbl_pkg::WORD_RESET;
      addr_s2_q <= pbl_pkg::WORD_RESET;
    end
    else
    begin
      ack_s1_q <= link.ack_flag_out;
      ack_s2_q <= ack_s1_q;
      rd_s1_q <= link.io_rd;
      rd_s2_q <= rd_s1_q;
      addr_s1_q <= link.io_addr;
      addr_s2_q <= addr_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sender state machine
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= pbl_pkg::HST_IDLE;
      strobe_q <= pbl_pkg::STROBE_RESET;
      oe_q <= 1'b0;
      data_q <= pbl_pkg::WORD_RESET;
      lo_q <= 1'b0;
      pop_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      pop_q <= 1'b0;
      busy_q <= fifo_valid || (state_q != pbl_pkg::HST_IDLE);
      case (state_q)
        pbl_pkg::HST_IDLE:
        begin
          // Selection read is answered while idle, ahead of any piece
          if (sel_rd)
          begin
            data_q <= boot_sel;
            oe_q <= 1'b1;
          end
          // Next piece only once ack is seen low [R5]
          else if (fifo_valid && !ack_s2_q)
          begin
            data_q <= send_val;   // High byte first [R7]
            oe_q <= 1'b1;
            state_q <= pbl_pkg::HST_SETUP;
          end
          else
            oe_q <= 1'b0;
        end
        pbl_pkg::HST_SETUP:
        begin
          // Data settled a cycle before the strobe falls [R3]
          strobe_q <= 1'b0;
          state_q <= pbl_pkg::HST_STRB;
        end
        pbl_pkg::HST_STRB:
        begin
          // Ack high: release the bus and the strobe [R10]
          if (ack_s2_q)
          begin
            strobe_q <= 1'b1;
            oe_q <= 1'b0;
            pop_q <= last_piece;
            lo_q <= byte_mode && !lo_q;
            state_q <= pbl_pkg::HST_WAIT;
          end
        end
        default:
        begin
          // Wait for ack low before the next piece [R5]
          if (!ack_s2_q)
            state_q <= pbl_pkg::HST_IDLE;
        end
      endcase
    end
  end
endmodule : pbl_host

// ### pbl_loader.sv
// Device end: parallel I/O boot loader writing program memory
//
// Behaviour
// R1 - Code words come from I/O port zero
// R2 - Port width is 16 or 8 bits
// R3 - Strobe low: read port, raise ack, store
// R4 - Ack stays high until strobe returns high
// R5 - Host waits for ack low before next word
// R6 - Byte mode uses low eight data lines only
// R7 - Byte mode: high byte first, then low byte
// R8 - First word destination, second word length
// R9 - Ten clocks from ack rise to write
// R10 - Memory bus driven only while ack high
// R11 - Increment pointer; zero length ends, else decrement
// R12 - Ack flag resets high
// R13 - Length holds code word count minus one
// R14 - Mode from low byte of port FFFFh
// R15 - Strobe synchronised, each level seen once
`timescale 1ns/100ps
module pbl_loader (
  input wire logic clk,
  input wire logic rst_b,
  pbl_link_if.dev_mp link,
  output logic [15:0] prog_addr,
  output logic [15:0] prog_data,
  output logic prog_we,
  output logic prog_bus_oe,
  output logic byte_mode,
  output logic boot_done,
  output logic boot_err,
  output logic [15:0] entry_addr
);
  pbl_pkg::pbl_dev_state_t state_q;  // Loader state
  pbl_pkg::pbl_phase_t phase_q;      // Which header or code word is next
  logic strb_s1_q;                   // Strobe sync stage 1
  logic strb_s2_q;                   // Strobe sync stage 2
  logic [15:0] dat_s1_q;             // Port data sync stage 1
  logic [15:0] dat_s2_q;             // Port data sync stage 2
  logic [15:0] rx_q;                 // Value taken from the port
  logic [7:0] high_byte_q;           // Held high byte
  logic lo_q;                        // Low byte is next in byte mode
  logic [15:0] dest_q;               // Destination, also entry point
  logic [15:0] ptr_q;                // Program memory pointer
  logic [15:0] len_q;                // Remaining count minus one
  logic last_q;                      // Final code word stored
  logic [3:0] cnt_q;                 // Delay counter
  logic ack_q;                       // Acknowledge flag pin
  logic io_rd_q;                     // I/O read strobe
  logic [15:0] io_addr_q;            // I/O address
  logic [15:0] prog_addr_q;          // Program memory write address
  logic [15:0] prog_data_q;          // Program memory write word
  logic prog_we_q;                   // One-cycle write pulse
  logic prog_bus_oe_q;               // Memory bus drive enable
  logic byte_mode_q;
  logic done_q;
  logic err_q;
  logic [15:0] entry_q;

  // Decoding of selection word, strobe level and assembled word
  wire [3:0] sel_nib = dat_s2_q[3:0];                             // [R14]
  wire sel_byte = (sel_nib == pbl_pkg::SEL_IO_BYTE);
  wire sel_word = (sel_nib == pbl_pkg::SEL_IO_WORD);
  wire strobe_low = !strb_s2_q;
  wire [15:0] word_in = byte_mode_q ? {high_byte_q, rx_q[7:0]} : rx_q;   // [R6] [R7]
  wire need_hi = byte_mode_q && !lo_q;
  wire write_due = (cnt_q == pbl_pkg::WRITE_DLY_CYC - 4'h1);
  wire sel_due = (cnt_q == pbl_pkg::SEL_WAIT_CYC);

  // Every top output straight from a flop
  assign link.ack_flag_out = ack_q;
  assign link.io_rd = io_rd_q;
  assign link.io_addr = io_addr_q;
  assign prog_addr = prog_addr_q;
  assign prog_data = prog_data_q;
  assign prog_we = prog_we_q;
  assign prog_bus_oe = prog_bus_oe_q;
  assign byte_mode = byte_mode_q;
  assign boot_done = done_q;
  assign boot_err = err_q;
  assign entry_addr = entry_q;

  //////////////////////////////////////////////////////////////////////////////
  // Host pins pass two flops; stage one feeds stage two only
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strb_s1_q <= pbl_pkg::STROBE_RESET;
      strb_s2_q <= pbl_pkg::STROBE_RESET;
      dat_s1_q <= pbl_pkg::WORD_RESET;
      dat_s2_q <= pbl_pkg::WORD_RESET;
    end
    else
    begin
      strb_s1_q <= link.host_strobe_in;  // [R15]
      strb_s2_q <= strb_s1_q;
      dat_s1_q <= link.port_data;
      dat_s2_q <= dat_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Handshake and sequencing state machine
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= pbl_pkg::DEV_SEL;
      phase_q <= pbl_pkg::PH_DEST;
      ack_q <= pbl_pkg::ACK_RESET;           // [R12]
      io_rd_q <= 1'b1;
      io_addr_q <= pbl_pkg::SEL_PORT_ADDR;   // [R14]
      cnt_q <= pbl_pkg::CNT_RESET;
      rx_q <= pbl_pkg::WORD_RESET;
      high_byte_q <= 8'h00;
      lo_q <= 1'b0;
      dest_q <= pbl_pkg::WORD_RESET;
      ptr_q <= pbl_pkg::WORD_RESET;
      len_q <= pbl_pkg::WORD_RESET;
      last_q <= 1'b0;
      prog_addr_q <= pbl_pkg::WORD_RESET;
      prog_data_q <= pbl_pkg::WORD_RESET;
      prog_we_q <= 1'b0;
      prog_bus_oe_q <= 1'b0;
      byte_mode_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      entry_q <= pbl_pkg::WORD_RESET;
    end
    else
    begin
      case (state_q)
        pbl_pkg::DEV_SEL:
        begin
          // Hold the selection read long enough for both sync chains
          cnt_q <= cnt_q + 4'h1;
          if (sel_due)
          begin
            io_rd_q <= 1'b0;
            io_addr_q <= pbl_pkg::IO_PORT_ADDR;  // [R1]
            cnt_q <= pbl_pkg::CNT_RESET;
            // Width chosen once, here [R2]
            if (sel_byte || sel_word)
            begin
              byte_mode_q <= sel_byte;
              ack_q <= 1'b0;                    // Ready to receive
              state_q <= pbl_pkg::DEV_WAIT_LO;
            end
            else
            begin
              // Modes not built here park the loader
              err_q <= 1'b1;
              state_q <= pbl_pkg::DEV_ERR;
            end
          end
        end
        pbl_pkg::DEV_WAIT_LO:
        begin
          // Strobe low: take port zero, raise ack [R3] [R15]
          if (strobe_low)
          begin
            io_rd_q <= 1'b1;                    // [R1]
            rx_q <= dat_s2_q;
            ack_q <= 1'b1;
            cnt_q <= pbl_pkg::CNT_RESET;
            state_q <= pbl_pkg::DEV_HOLD;
          end
        end
        pbl_pkg::DEV_HOLD:
        begin
          io_rd_q <= 1'b0;
          cnt_q <= cnt_q + 4'h1;
          // Write lands ten clocks after ack rose [R9]
          if (write_due)
          begin
            state_q <= pbl_pkg::DEV_WAIT_HI;
            if (need_hi)
            begin
              high_byte_q <= rx_q[7:0];         // [R6] [R7]
              lo_q <= 1'b1;
            end
            else
            begin
              lo_q <= 1'b0;
              case (phase_q)
                pbl_pkg::PH_DEST:
                begin
                  dest_q <= word_in;            // [R8]
                  ptr_q <= word_in;
                  phase_q <= pbl_pkg::PH_LEN;
                end
                pbl_pkg::PH_LEN:
                begin
                  len_q <= word_in;             // [R8] [R13]
                  phase_q <= pbl_pkg::PH_CODE;
                end
                default:
                begin
                  // Store while ack is high; host is off the bus [R3] [R10]
                  prog_addr_q <= ptr_q;
                  prog_data_q <= word_in;
                  prog_we_q <= 1'b1;
                  prog_bus_oe_q <= 1'b1;
                  ptr_q <= ptr_q + 16'h0001;    // [R11]
                  // Zero remaining means this was word N [R11] [R13]
                  if (len_q == 16'h0000)
                    last_q <= 1'b1;
                  else
                    len_q <= len_q - 16'h0001;
                end
              endcase
            end
          end
        end
        pbl_pkg::DEV_WAIT_HI:
        begin
          // Bus dropped on the same edge that ack can fall [R10]
          prog_we_q <= 1'b0;
          prog_bus_oe_q <= 1'b0;
          // Ack held until the strobe is back high [R4] [R15]
          if (!strobe_low)
          begin
            ack_q <= 1'b0;
            if (last_q)
            begin
              // Branch to the destination [R11]
              entry_q <= dest_q;
              done_q <= 1'b1;
              state_q <= pbl_pkg::DEV_DONE;
            end
            else
              state_q <= pbl_pkg::DEV_WAIT_LO;
          end
        end
        default:
        begin
          // Done or error: hold everything, reset leaves
          prog_we_q <= 1'b0;
          prog_bus_oe_q <= 1'b0;
        end
      endcase
    end
  end
endmodule : pbl_loader

// ### pbl_link_monitor.sv
// Concurrent checks on the strobe/ack link between host and loader
`timescale 1ns/100ps
module pbl_link_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_strobe_in,
  input wire logic ack_flag_out,
  input wire logic [15:0] port_data,
  input wire logic port_data_oe,
  input wire logic [15:0] io_addr,
  input wire logic io_rd
);
  // One clock domain, so one default clocking and disable
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////
  // Selection read window just after reset release
  sequence sel_win;
    (io_rd && io_addr == pbl_pkg::SEL_PORT_ADDR) [*8];
  endsequence
  // Strobe taken: ack low, then high within the sync delay
  sequence ack_rise;
    !ack_flag_out ##[1:4] ack_flag_out;
  endsequence

  ////////////////////////////////////////////////////////////////
  a_ack_reset_high: assert property ($rose(rst_b) |-> ack_flag_out)
    else $error("ack not high after reset");
  a_sel_read_addr: assert property ($rose(rst_b) |-> sel_win)
    else $error("selection read not at top port");
  a_ack_on_strobe: assert property ($fell(host_strobe_in) && !ack_flag_out |-> ack_rise)
    else $error("strobe not acknowledged in time");
  a_ack_hold_high: assert property (ack_flag_out && !host_strobe_in |=> ack_flag_out)
    else $error("ack dropped while strobe low");
  a_ack_fall_cause: assert property ($fell(ack_flag_out) |-> $past(host_strobe_in, 2))
    else $error("ack fell without strobe high");
  a_host_waits_ack: assert property ($fell(host_strobe_in) |-> !$past(ack_flag_out))
    else $error("strobe fell while ack high");
  a_data_held_steady: assert property (!host_strobe_in |-> port_data_oe && $stable(port_data))
    else $error("port data moved under strobe");
  a_take_port_zero: assert property ($rose(ack_flag_out) |-> io_addr == pbl_pkg::IO_PORT_ADDR)
    else $error("take not from port zero");
  a_idle_port_zero: assert property (!ack_flag_out |-> io_addr == pbl_pkg::IO_PORT_ADDR)
    else $error("idle address not port zero");
endmodule : pbl_link_monitor

// ### parallel_io_boot_loader_tb.sv
// Testbench: host and loader back to back, plus a rule-breaking driver
`timescale 1ns/100ps
module parallel_io_boot_loader_tb;
  logic clk, rst_b, byte_mode, word_valid;
  logic [15:0] boot_sel, word_data;
  logic word_ready, busy, prog_we, prog_bus_oe, bm_o, done, err;
  logic [15:0] prog_addr, prog_data, entry;
  logic prog_we2, done2, err2, bm2;
  logic [15:0] prog_addr2, prog_data2, entry2;
  logic [15:0] w; // Destination word of test 3
  logic [31:0] exp_q[$]; // Model: expected {addr, data} writes
  logic [15:0] tx_q[$]; // Words still to push
  logic [31:0] w2;
  logic ack_prev;
  int err_count, tests_run, cyc, refused, pushed, w2_cnt, seed_v;

  pbl_link_if u_pbl_link_if ();
  pbl_link_if u_pbl_link_if_2 ();
  pbl_host u_pbl_host (.clk(clk), .rst_b(rst_b), .byte_mode(byte_mode), .boot_sel(boot_sel),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data), .busy(busy),
    .link(u_pbl_link_if));
  pbl_loader u_pbl_loader (.clk(clk), .rst_b(rst_b), .link(u_pbl_link_if), .prog_addr(prog_addr),
    .prog_data(prog_data), .prog_we(prog_we), .prog_bus_oe(prog_bus_oe), .byte_mode(bm_o),
    .boot_done(done), .boot_err(err), .entry_addr(entry));
  // Second loader faces the bench's own driver
  pbl_loader u_pbl_loader_2 (.clk(clk), .rst_b(rst_b), .link(u_pbl_link_if_2), .prog_addr(prog_addr2),
    .prog_data(prog_data2), .prog_we(prog_we2), .prog_bus_oe(), .byte_mode(bm2),
    .boot_done(done2), .boot_err(err2), .entry_addr(entry2));
  pbl_link_monitor u_mon (.clk(clk), .rst_b(rst_b), .host_strobe_in(u_pbl_link_if.host_strobe_in),
    .ack_flag_out(u_pbl_link_if.ack_flag_out), .port_data(u_pbl_link_if.port_data),
    .port_data_oe(u_pbl_link_if.port_data_oe), .io_addr(u_pbl_link_if.io_addr),
    .io_rd(u_pbl_link_if.io_rd));

  // 50 MHz clock
  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Pre-edge view of a few outputs
  function logic pick(input int s);
    case (s)
      0: pick = done;
      1: pick = u_pbl_link_if_2.ack_flag_out;
      2: pick = done2;
      default: pick = err2;
    endcase
  endfunction : pick

  // Bounded wait; a hang ends the run
  task wait_for(input int s, input logic v);
    int g;
    begin
      g = 0;
      do
      begin
        @(posedge clk);
        g++;
      end
      while (pick(s) !== v && g < 5000);
      if (g >= 5000)
      begin
        err_count++;
        results();
      end
    end
  endtask : wait_for

  ////////////////////////////////////////////////////////////////
  // Write checker: every program write of the first loader against the model
  always @(posedge clk)
  begin
    if (!rst_b)
      ack_prev = 1'b1;
    else
    begin
      cyc = (u_pbl_link_if.ack_flag_out === 1'b1 && ack_prev === 1'b0) ? 0 : cyc + 1;
      ack_prev = u_pbl_link_if.ack_flag_out;
      if (prog_bus_oe !== 1'b0)
        chk({31'h0, u_pbl_link_if.ack_flag_out}, 1);
      if (prog_we === 1'b1)
      begin
        chk({prog_addr, prog_data}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFF_FFFF);
        chk(32'(cyc >= 10), 1);
        chk({31'h0, prog_bus_oe}, 1);
      end
      // Second loader: keep the last write
      if (prog_we2 === 1'b1)
      begin
        w2_cnt++;
        w2 = {prog_addr2, prog_data2};
      end
    end
  end

  // Driver byte for the second loader, optionally breaking the wait rule
  task drv_byte(input logic [7:0] b, input logic gl);
    u_pbl_link_if_2.port_data <= {8'($urandom), b}; // Junk on upper lines
    wait_for(1, 1'b0);
    u_pbl_link_if_2.host_strobe_in <= 1'b0;
    wait_for(1, 1'b1);
    if (gl)
    begin
      // Strobe low again while ack high: no new transfer
      u_pbl_link_if_2.host_strobe_in <= 1'b1;
      @(posedge clk);
      u_pbl_link_if_2.host_strobe_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
    u_pbl_link_if_2.host_strobe_in <= 1'b1;
  endtask : drv_byte

  // Reset, push a full boot image through the host, check the result
  task run_host(input logic bm, input int n, input logic [3:0] sel2);
    logic [15:0] d;
    logic [15:0] w;
    int k;
    begin
      d = 16'($urandom);
      tx_q = {d, 16'(n - 1)};
      for (k = 0; k < n; k++)
      begin
        w = 16'($urandom);
        tx_q.push_back(w);
        exp_q.push_back({d + 16'(k), w});
      end
      rst_b <= 1'b0;
      byte_mode <= bm;
      boot_sel <= {12'($urandom), bm ? pbl_pkg::SEL_IO_BYTE : pbl_pkg::SEL_IO_WORD};
      u_pbl_link_if_2.port_data <= {12'($urandom), sel2};
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      refused = 0;
      pushed = 0;
      k = 0;
      // Push as fast as the FIFO takes; the slow handshake stalls it
      while (tx_q.size() > 0 && k < 20000)
      begin
        word_valid <= 1'b1;
        word_data <= tx_q[0];
        @(posedge clk);
        k++;
        if (word_ready === 1'b1)
        begin
          void'(tx_q.pop_front());
          pushed++;
        end
        else if (refused == 0)
          refused = pushed;
      end
      word_valid <= 1'b0;
      // Words left over mean the push loop ran out: a hang
      if (tx_q.size() > 0)
      begin
        err_count++;
        results();
      end
      wait_for(0, 1'b1);
      chk(entry, d);
      chk({31'h0, bm_o}, {31'h0, bm});
      chk({31'h0, err}, 0);
      chk(32'(exp_q.size()), 0);
      repeat (4) @(posedge clk);
      chk({31'h0, busy}, 0);
    end
  endtask : run_host

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    byte_mode = 1'b0;
    word_valid = 1'b0;
    boot_sel = 16'h0000;
    word_data = 16'h0000;
    u_pbl_link_if_2.host_strobe_in = 1'b1;
    u_pbl_link_if_2.port_data_oe = 1'b1;
    u_pbl_link_if_2.port_data = 16'h0000;
    err_count = 0;
    tests_run = 0;
    w2_cnt = 0;
    cyc = 0;
    seed_v = $urandom(32'h2fd7_b464);
    // Word mode, long image fills the FIFO; second loader gets a bad mode
    run_host(1'b0, 40, 4'h3);
    chk(32'(refused >= pbl_pkg::FIFO_DEPTH), 1);
    chk({err2, u_pbl_link_if_2.ack_flag_out}, 2'b11);
    chk(32'(w2_cnt), 0);
    $display("test 1 done, mismatches %0d", err_count);
    // Byte mode, one code word (length zero)
    run_host(1'b1, 1, pbl_pkg::SEL_IO_BYTE);
    $display("test 2 done, mismatches %0d", err_count);
    // Second loader in byte mode, host breaks the wait rule once
    w = 16'($urandom);
    drv_byte(w[15:8], 1'b0);
    drv_byte(w[7:0], 1'b0);
    drv_byte(8'h00, 1'b0);
    drv_byte(8'h00, 1'b0);
    drv_byte(8'hA5, 1'b0);
    drv_byte(8'h3C, 1'b1);
    wait_for(2, 1'b1);
    chk(w2, {w, 16'hA53C});
    chk(32'(w2_cnt), 1);
    chk(entry2, w);
    chk({31'h0, bm2}, 1);
    $display("test 3 done, mismatches %0d", err_count);
    results();
  end
endmodule : parallel_io_boot_loader_tb
